//--- verilog/tcc_timer.sv
// three-channel 16-bit timer block with capture and waveform modes
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_timer #(
	parameter int NCH = 3
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [31:0] RDATA_OUT,
	input wire logic [NCH-1:0] IO_A_IN,
	output logic [NCH-1:0] IO_A_OUT,
	output logic [NCH-1:0] IO_A_OE_N_OUT,
	input wire logic [NCH-1:0] IO_B_IN,
	output logic [NCH-1:0] IO_B_OUT,
	output logic [NCH-1:0] IO_B_OE_N_OUT,
	input wire logic [2:0] EXT_CLK_IN,
	output logic [NCH-1:0] IRQ_OUT
);
	localparam int NIN = 2 * NCH + 3;

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [NIN-1:0] pin_w; // line A, line B, ext clock lines
	logic [NIN-1:0] s1_q; // first stage, feeds s2 only
	logic [NIN-1:0] s2_q;
	logic [NIN-1:0] s3_q;
	logic [NIN-1:0] lvl_q; // accepted level
	logic [NIN-1:0] rise_w;
	logic [NIN-1:0] fall_w;

	assign pin_w = {EXT_CLK_IN, IO_B_IN, IO_A_IN};

	// three-stage chain against metastability
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_w;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			lvl_q <= '0;
		end else begin
			for (int i = 0; i < NIN; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					lvl_q[i] <= s3_q[i];
				end
			end
		end
	end

	// edges seen against the accepted level
	assign rise_w = ~lvl_q & s2_q & s3_q;
	assign fall_w = lvl_q & ~s2_q & ~s3_q;

	// ****************************************
	// helpers
	// ****************************************
	// edge code: bit 0 rising, bit 1 falling, both for each edge
	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		return (sel[0] & r) | (sel[1] & f);
	endfunction

	// new line level for one action code
	function automatic logic out_act(input logic [1:0] a, input logic cur);
		case (a)
			tcc_pkg::TCC_ACT_SET: out_act = 1'b1;
			tcc_pkg::TCC_ACT_CLR: out_act = 1'b0;
			tcc_pkg::TCC_ACT_TGL: out_act = ~cur;
			default: out_act = cur;
		endcase
	endfunction

	// ****************************************
	// channel state
	// ****************************************
	logic [31:0] mode_q [NCH]; // channel mode
	logic [15:0] cnt_q [NCH]; // counter value
	logic [15:0] capa_q [NCH]; // capture / match A
	logic [15:0] capb_q [NCH]; // capture / match B
	logic [15:0] perd_q [NCH]; // period compare
	logic [7:0] sr_q [NCH]; // sticky flags
	logic [7:0] imr_q [NCH]; // interrupt mask
	logic [NCH-1:0] en_q; // counter clock enabled
	logic [NCH-1:0] run_q; // counter clock started
	logic [NCH-1:0] armed_q; // A loaded, B not yet
	logic [NCH-1:0] unrd_a_q; // A holds an unread value
	logic [NCH-1:0] unrd_b_q; // B holds an unread value
	logic [5:0] bmr_q; // clock routing, stored only

	// ****************************************
	// bus decode
	// ****************************************
	logic [5:0] reg_w;
	logic sync_w; // block-wide software trigger
	logic [NCH-1:0] sel_w; // channel addressed

	assign reg_w = ADDR_IN[5:0];
	assign sync_w = WR_IN & (ADDR_IN == `TCC_OFS_BCR) & WDATA_IN[`TCC_BCR_SYNC];

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			sel_w[c] = (ADDR_IN[7:6] == 2'(c));
		end
	end

	// ****************************************
	// per-channel events
	// ****************************************
	logic [NCH-1:0] wave_w, tick_w, ma_w, mb_w, mc_w, ovf_w, sw_w;
	logic [NCH-1:0] ev_w, ext_w, trg_w, lda_w, ldb_w, ovr_w;
	logic [NCH-1:0] stop_w, dis_w;

	always_comb begin
		logic [31:0] m;
		logic tr, tf, er, ef;
		m = '0;
		tr = 1'b0;
		tf = 1'b0;
		er = 1'b0;
		ef = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			m = mode_q[c];
			wave_w[c] = m[`TCC_F_WAVE];
			tick_w[c] = en_q[c] & run_q[c];
			// compares only count while the counter advances
			ma_w[c] = wave_w[c] & tick_w[c] & (cnt_q[c] == capa_q[c]);
			mb_w[c] = wave_w[c] & tick_w[c] & (cnt_q[c] == capb_q[c]);
			mc_w[c] = tick_w[c] & (cnt_q[c] == perd_q[c]);
			ovf_w[c] = tick_w[c] & (cnt_q[c] == `TCC_CNT_TOP);
			sw_w[c] = (WR_IN & sel_w[c] & (reg_w == `TCC_OFS_CCR)
				& WDATA_IN[`TCC_CCR_SWTRG]) | sync_w;
			// capture trigger line
			if (m[`TCC_F_LINE]) begin
				tr = rise_w[c];
				tf = fall_w[c];
			end else begin
				tr = rise_w[NCH + c];
				tf = fall_w[NCH + c];
			end
			// waveform event source
			case (m[`TCC_F_SRC +: 2])
				2'h0: begin
					er = rise_w[NCH + c];
					ef = fall_w[NCH + c];
				end
				2'h1: begin
					er = rise_w[2 * NCH];
					ef = fall_w[2 * NCH];
				end
				2'h2: begin
					er = rise_w[2 * NCH + 1];
					ef = fall_w[2 * NCH + 1];
				end
				default: begin
					er = rise_w[2 * NCH + 2];
					ef = fall_w[2 * NCH + 2];
				end
			endcase
			ev_w[c] = wave_w[c] & edge_hit(m[`TCC_F_EDGE +: 2], er, ef);
			ext_w[c] = ~wave_w[c] & edge_hit(m[`TCC_F_EDGE +: 2], tr, tf);
			// event becomes a trigger only when enabled
			trg_w[c] = sw_w[c] | ext_w[c] | (ev_w[c] & m[`TCC_F_EVTRG])
				| (m[`TCC_F_PTRG] & mc_w[c]);
			// capture loads, alternating A then B
			lda_w[c] = ~wave_w[c] & ~armed_q[c]
				& edge_hit(m[`TCC_F_LDA +: 2], rise_w[c], fall_w[c]);
			ldb_w[c] = ~wave_w[c] & armed_q[c]
				& edge_hit(m[`TCC_F_LDB +: 2], rise_w[c], fall_w[c]);
			ovr_w[c] = (lda_w[c] & unrd_a_q[c]) | (ldb_w[c] & unrd_b_q[c]);
			// stop/disable from period match or B load
			stop_w[c] = wave_w[c] ? (mc_w[c] & m[`TCC_F_STOP]) : (ldb_w[c] & m[`TCC_F_STOP]);
			dis_w[c] = wave_w[c] ? (mc_w[c] & m[`TCC_F_DIS]) : (ldb_w[c] & m[`TCC_F_DIS]);
		end
	end

	// ****************************************
	// counter clock control
	// ****************************************
	// disable beats enable; a stop beats a start in the same cycle
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			en_q <= '0;
			run_q <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (dis_w[c] | (WR_IN & sel_w[c] & (reg_w == `TCC_OFS_CCR)
					& WDATA_IN[`TCC_CCR_CLKDIS])) begin
					en_q[c] <= 1'b0;
				end else if (WR_IN & sel_w[c] & (reg_w == `TCC_OFS_CCR)
					& WDATA_IN[`TCC_CCR_CLKEN]) begin
					en_q[c] <= 1'b1;
				end
				if (stop_w[c]) begin
					run_q[c] <= 1'b0;
				end else if (trg_w[c] & en_q[c]) begin
					run_q[c] <= 1'b1;
				end
			end
		end
	end

	// ****************************************
	// counter
	// ****************************************
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			for (int c = 0; c < NCH; c++) begin
				cnt_q[c] <= `TCC_RST_CNT;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (WR_IN & sel_w[c] & (reg_w == `TCC_OFS_CV)) begin
					cnt_q[c] <= WDATA_IN[15:0];
				end else if (trg_w[c]) begin
					cnt_q[c] <= `TCC_RST_CNT;
				end else if (tick_w[c]) begin
					cnt_q[c] <= cnt_q[c] + 16'h0001; // wraps past top
				end
			end
		end
	end

	// ****************************************
	// mode, compare and capture registers
	// ****************************************
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			bmr_q <= `TCC_RST_BMR;
			for (int c = 0; c < NCH; c++) begin
				mode_q[c] <= `TCC_RST_CMR;
				capa_q[c] <= `TCC_RST_CNT;
				capb_q[c] <= `TCC_RST_CNT;
				perd_q[c] <= `TCC_RST_CNT;
				imr_q[c] <= 8'h00;
			end
		end else begin
			if (WR_IN & (ADDR_IN == `TCC_OFS_BMR)) begin
				bmr_q <= WDATA_IN[5:0];
			end
			for (int c = 0; c < NCH; c++) begin
				if (WR_IN & sel_w[c] & (reg_w == `TCC_OFS_CMR)) begin
					mode_q[c] <= WDATA_IN;
				end
				// hardware load has priority over software write
				if (lda_w[c]) begin
					capa_q[c] <= cnt_q[c];
				end else if (WR_IN & sel_w[c] & wave_w[c] & (reg_w == `TCC_OFS_CAPA)) begin
					capa_q[c] <= WDATA_IN[15:0];
				end
				if (ldb_w[c]) begin
					capb_q[c] <= cnt_q[c];
				end else if (WR_IN & sel_w[c] & wave_w[c] & (reg_w == `TCC_OFS_CAPB)) begin
					capb_q[c] <= WDATA_IN[15:0];
				end
				if (WR_IN & sel_w[c] & (reg_w == `TCC_OFS_PERD)) begin
					perd_q[c] <= WDATA_IN[15:0];
				end
				// mask: enable and disable writes
				if (WR_IN & sel_w[c] & (reg_w == `TCC_OFS_IER)) begin
					imr_q[c] <= imr_q[c] | WDATA_IN[7:0];
				end else if (WR_IN & sel_w[c] & (reg_w == `TCC_OFS_IDR)) begin
					imr_q[c] <= imr_q[c] & ~WDATA_IN[7:0];
				end
			end
		end
	end

	// ****************************************
	// capture sequencing and unread tracking
	// ****************************************
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			armed_q <= '0;
			unrd_a_q <= '0;
			unrd_b_q <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (trg_w[c]) begin
					armed_q[c] <= 1'b0;
				end else if (lda_w[c]) begin
					armed_q[c] <= 1'b1;
				end else if (ldb_w[c]) begin
					armed_q[c] <= 1'b0;
				end
				// a load in the read cycle wins
				if (lda_w[c]) begin
					unrd_a_q[c] <= 1'b1;
				end else if (RD_IN & sel_w[c] & (reg_w == `TCC_OFS_CAPA)) begin
					unrd_a_q[c] <= 1'b0;
				end
				if (ldb_w[c]) begin
					unrd_b_q[c] <= 1'b1;
				end else if (RD_IN & sel_w[c] & (reg_w == `TCC_OFS_CAPB)) begin
					unrd_b_q[c] <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// sticky status flags
	// ****************************************
	// clear on read, but a new event in that cycle is kept
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			for (int c = 0; c < NCH; c++) begin
				sr_q[c] <= 8'h00;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				logic [7:0] keep;
				logic [7:0] set;
				keep = sr_q[c];
				set = 8'h00;
				if (RD_IN & sel_w[c] & (reg_w == `TCC_OFS_SR)) begin
					keep = 8'h00;
				end
				if (RD_IN & sel_w[c] & (reg_w == `TCC_OFS_CAPA)) begin
					keep[`TCC_SR_LDA] = 1'b0;
				end
				if (RD_IN & sel_w[c] & (reg_w == `TCC_OFS_CAPB)) begin
					keep[`TCC_SR_LDB] = 1'b0;
				end
				set[`TCC_SR_WRAP] = ovf_w[c];
				set[`TCC_SR_OVR] = ovr_w[c];
				set[`TCC_SR_MA] = ma_w[c];
				set[`TCC_SR_MB] = mb_w[c];
				set[`TCC_SR_PER] = mc_w[c];
				set[`TCC_SR_LDA] = lda_w[c];
				set[`TCC_SR_LDB] = ldb_w[c];
				set[`TCC_SR_ETRG] = ext_w[c] | ev_w[c];
				sr_q[c] <= keep | set;
			end
		end
	end

	// interrupt line follows flags under mask, one cycle late
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			IRQ_OUT <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				IRQ_OUT[c] <= |(sr_q[c] & imr_q[c]);
			end
		end
	end

	// ****************************************
	// output controller
	// ****************************************
	// first event with a real action wins; lines hold in capture mode
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			IO_A_OUT <= '0;
			IO_B_OUT <= '0;
			IO_A_OE_N_OUT <= '1;
			IO_B_OE_N_OUT <= '1;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				logic [31:0] m;
				m = mode_q[c];
				IO_A_OE_N_OUT[c] <= ~wave_w[c];
				IO_B_OE_N_OUT[c] <= ~(wave_w[c] & (m[`TCC_F_SRC +: 2] != 2'h0));
				if (wave_w[c]) begin
					if (sw_w[c] & (|m[`TCC_F_ASOFT +: 2])) begin
						IO_A_OUT[c] <= out_act(m[`TCC_F_ASOFT +: 2], IO_A_OUT[c]);
					end else if (ev_w[c] & (|m[`TCC_F_AEVT +: 2])) begin
						IO_A_OUT[c] <= out_act(m[`TCC_F_AEVT +: 2], IO_A_OUT[c]);
					end else if (mc_w[c] & (|m[`TCC_F_APER +: 2])) begin
						IO_A_OUT[c] <= out_act(m[`TCC_F_APER +: 2], IO_A_OUT[c]);
					end else if (ma_w[c] & (|m[`TCC_F_AMATCH +: 2])) begin
						IO_A_OUT[c] <= out_act(m[`TCC_F_AMATCH +: 2], IO_A_OUT[c]);
					end
					if (sw_w[c] & (|m[`TCC_F_BSOFT +: 2])) begin
						IO_B_OUT[c] <= out_act(m[`TCC_F_BSOFT +: 2], IO_B_OUT[c]);
					end else if (ev_w[c] & (|m[`TCC_F_BEVT +: 2])) begin
						IO_B_OUT[c] <= out_act(m[`TCC_F_BEVT +: 2], IO_B_OUT[c]);
					end else if (mc_w[c] & (|m[`TCC_F_BPER +: 2])) begin
						IO_B_OUT[c] <= out_act(m[`TCC_F_BPER +: 2], IO_B_OUT[c]);
					end else if (mb_w[c] & (|m[`TCC_F_BMATCH +: 2])) begin
						IO_B_OUT[c] <= out_act(m[`TCC_F_BMATCH +: 2], IO_B_OUT[c]);
					end
				end
			end
		end
	end

	// ****************************************
	// read data
	// ****************************************
	// stands only in the cycle after the read strobe
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN) begin
			RDATA_OUT <= '0;
		end else begin
			RDATA_OUT <= '0;
			if (RD_IN) begin
				if (ADDR_IN == `TCC_OFS_BMR) begin
					RDATA_OUT <= {26'h0, bmr_q};
				end
				for (int c = 0; c < NCH; c++) begin
					if (sel_w[c]) begin
						case (reg_w)
							`TCC_OFS_CMR: RDATA_OUT <= mode_q[c];
							`TCC_OFS_CV: RDATA_OUT <= {16'h0, cnt_q[c]};
							`TCC_OFS_CAPA: RDATA_OUT <= {16'h0, capa_q[c]};
							`TCC_OFS_CAPB: RDATA_OUT <= {16'h0, capb_q[c]};
							`TCC_OFS_PERD: RDATA_OUT <= {16'h0, perd_q[c]};
							`TCC_OFS_SR: RDATA_OUT <= {15'h0, en_q[c], 8'h0, sr_q[c]};
							`TCC_OFS_IMR: RDATA_OUT <= {24'h0, imr_q[c]};
							default: RDATA_OUT <= '0;
						endcase
					end
				end
			end
		end
	end
endmodule

//--- verilog/tcc_regs.svh
// register offsets, field positions and reset values of the timer channel block
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
// ****************************************
// channel register offsets (low six address bits)
// ****************************************
`define TCC_OFS_CCR 6'h00
`define TCC_OFS_CMR 6'h04
`define TCC_OFS_CV 6'h10
`define TCC_OFS_CAPA 6'h14
`define TCC_OFS_CAPB 6'h18
`define TCC_OFS_PERD 6'h1C
`define TCC_OFS_SR 6'h20
`define TCC_OFS_IER 6'h24
`define TCC_OFS_IDR 6'h28
`define TCC_OFS_IMR 6'h2C
// ****************************************
// block registers (full address)
// ****************************************
`define TCC_OFS_BCR 8'hC0
`define TCC_OFS_BMR 8'hC4
// ****************************************
// command bits
// ****************************************
`define TCC_CCR_CLKEN 0
`define TCC_CCR_CLKDIS 1
`define TCC_CCR_SWTRG 2
`define TCC_BCR_SYNC 0
// ****************************************
// mode register field positions
// ****************************************
`define TCC_F_STOP 6
`define TCC_F_DIS 7
`define TCC_F_EDGE 8
`define TCC_F_LINE 10
`define TCC_F_SRC 10
`define TCC_F_EVTRG 12
`define TCC_F_PTRG 14
`define TCC_F_WAVE 15
`define TCC_F_LDA 16
`define TCC_F_LDB 18
`define TCC_F_AMATCH 16
`define TCC_F_APER 18
`define TCC_F_AEVT 20
`define TCC_F_ASOFT 22
`define TCC_F_BMATCH 24
`define TCC_F_BPER 26
`define TCC_F_BEVT 28
`define TCC_F_BSOFT 30
// ****************************************
// status bit positions
// ****************************************
`define TCC_SR_WRAP 0
`define TCC_SR_OVR 1
`define TCC_SR_MA 2
`define TCC_SR_MB 3
`define TCC_SR_PER 4
`define TCC_SR_LDA 5
`define TCC_SR_LDB 6
`define TCC_SR_ETRG 7
`define TCC_SR_CLKSTA 16
// ****************************************
// reset values and counter top
// ****************************************
`define TCC_RST_CMR 32'h0000_0000
`define TCC_RST_CNT 16'h0000
`define TCC_RST_BMR 6'h00
`define TCC_CNT_TOP 16'hFFFF
`endif

//--- verilog/tcc_pkg.sv
// types shared by the timer channel block
package tcc_pkg;
	// edge choice for loads, triggers and events
	typedef enum logic [1:0] {
		TCC_EDGE_NONE = 2'h0,
		TCC_EDGE_RISE = 2'h1,
		TCC_EDGE_FALL = 2'h2,
		TCC_EDGE_BOTH = 2'h3
	} tcc_edge_t;
	// output action of one event
	typedef enum logic [1:0] {
		TCC_ACT_NONE = 2'h0,
		TCC_ACT_SET = 2'h1,
		TCC_ACT_CLR = 2'h2,
		TCC_ACT_TGL = 2'h3
	} tcc_act_t;
endpackage

//--- test/tcc_timer_sva.sv
// assertion checker for the timer block, watching channel 0 at the top ports
`timescale 1ns/1ps
module tcc_timer_sva #(
	parameter int NCH = 3
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [31:0] RDATA_OUT,
	input wire logic [NCH-1:0] IO_A_OUT,
	input wire logic [NCH-1:0] IO_A_OE_N_OUT,
	input wire logic [NCH-1:0] IO_B_OE_N_OUT,
	input wire logic [NCH-1:0] IRQ_OUT
);
	// ****
	// shadows of channel 0 mode and mask
	// ****
	logic [31:0] mode_q; // last mode word written
	logic [7:0] mask_q; // interrupt mask as built by set/clear
	logic b_in; // line b serves as event input
	logic b_drv; // line b should be driven
	logic no_mask; // nothing may raise the interrupt
	logic idle_a; // waveform with no action on line a
	assign b_in = mode_q[15] && mode_q[11:10] == 2'h0;
	assign b_drv = mode_q[15] && mode_q[11:10] != 2'h0;
	assign no_mask = mask_q == 8'h00;
	assign idle_a = mode_q[15] && mode_q[23:16] == 8'h00;
	// mode shadow follows bus writes
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN)
			mode_q <= 32'h0000_0000;
		else if (WR_IN && ADDR_IN == 8'h04)
			mode_q <= WDATA_IN;
	end
	// mask shadow: set and clear words act bitwise
	always_ff @(posedge CLK_SYS_IN) begin
		if (RST_IN)
			mask_q <= 8'h00;
		else if (WR_IN && ADDR_IN == 8'h24)
			mask_q <= mask_q | WDATA_IN[7:0];
		else if (WR_IN && ADDR_IN == 8'h28)
			mask_q <= mask_q & ~WDATA_IN[7:0];
	end
	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN);
	// ****
	// properties
	// ****
	a_rdata_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 32'h0000_0000)
		else $error("read data not zero outside a read");
	a_wo_read_zero: assert property ($past(RD_IN) && $past(ADDR_IN) inside
		{8'h00, 8'h08, 8'h24, 8'h28, 8'hC0} |-> RDATA_OUT == 32'h0000_0000)
		else $error("write-only or reserved place read nonzero");
	a_capture_inputs: assert property (!mode_q[15] && !$past(mode_q[15])
		|-> IO_A_OE_N_OUT[0] && IO_B_OE_N_OUT[0])
		else $error("line driven in capture mode");
	a_wave_drives_a: assert property (mode_q[15] && $past(mode_q[15]) |-> !IO_A_OE_N_OUT[0])
		else $error("line a not driven in waveform mode");
	a_event_b_input: assert property (b_in && $past(b_in) |-> IO_B_OE_N_OUT[0])
		else $error("line b driven while it is the event input");
	a_b_drives: assert property (b_drv && $past(b_drv) |-> !IO_B_OE_N_OUT[0])
		else $error("line b not driven in waveform mode");
	a_irq_masked: assert property (no_mask && $past(no_mask) |-> !IRQ_OUT[0])
		else $error("interrupt raised with empty mask");
	a_hold_no_action: assert property (idle_a && $past(idle_a) && $past(idle_a, 2)
		|-> $stable(IO_A_OUT[0]))
		else $error("line a moved with no action chosen");
	c_status_read: cover property (RD_IN && ADDR_IN == 8'h20);
	c_wave_rise: cover property (!IO_A_OE_N_OUT[0] && $rose(IO_A_OUT[0]));
	c_irq_rise: cover property ($rose(IRQ_OUT[0]));
endmodule

bind tcc_timer tcc_timer_sva #(.NCH(NCH)) i_tcc_timer_sva (.CLK_SYS_IN(CLK_SYS_IN),
	.RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
	.RDATA_OUT(RDATA_OUT), .IO_A_OUT(IO_A_OUT), .IO_A_OE_N_OUT(IO_A_OE_N_OUT),
	.IO_B_OE_N_OUT(IO_B_OE_N_OUT), .IRQ_OUT(IRQ_OUT));

//--- test/tcc_pins_model.sv
// model of the signals outside the timer block's i/o lines
`timescale 1ns/1ps
module tcc_pins_model #(
	parameter int NCH = 3
) (
	input wire logic clk_in,
	input wire logic [NCH-1:0] dev_a_in,
	input wire logic [NCH-1:0] dev_a_oe_n_in,
	input wire logic [NCH-1:0] dev_b_in,
	input wire logic [NCH-1:0] dev_b_oe_n_in,
	output logic [NCH-1:0] pin_a_out,
	output logic [NCH-1:0] pin_b_out,
	output logic [2:0] ext_clk_out
);
	logic [NCH-1:0] drv_a_q = '0; // level the outside source puts on line a
	logic [NCH-1:0] drv_b_q = '0; // same for line b
	// external clocks stand still: no clock source is modelled
	assign ext_clk_out = 3'h0;
	// wire level: device wins while its enable is low
	assign pin_a_out = (dev_a_oe_n_in & drv_a_q) | (~dev_a_oe_n_in & dev_a_in);
	assign pin_b_out = (dev_b_oe_n_in & drv_b_q) | (~dev_b_oe_n_in & dev_b_in);
	// high pulse on channel 0, width clocks long; callers give several so it is seen
	task automatic pulse(input int line, input int width);
		@(posedge clk_in);
		if (line == 0)
			drv_a_q[0] <= 1'b1;
		else
			drv_b_q[0] <= 1'b1;
		repeat (width) @(posedge clk_in);
		if (line == 0)
			drv_a_q[0] <= 1'b0;
		else
			drv_b_q[0] <= 1'b0;
	endtask
endmodule

//--- test/tb_top.sv
// self-checking bench for the three-channel timer block
`timescale 1ns/1ps
module tb_top;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} tcc_row_t;
	typedef struct {logic [31:0] m; int ln; logic e;} tcc_trig_t;
	logic clk, rst, wr, rd;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0] io_a_in, io_a_out, io_a_oe_n, io_b_in, io_b_out, io_b_oe_n, ext_clk, irq;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0; // cycle count, also the hang limit
	// ****
	// plain register cases: reset values, map, access kinds
	// ****
	tcc_row_t rows [15] = '{'{8'h04, 0, 0, 0}, '{8'h10, 0, 0, 0}, '{8'h14, 0, 0, 0},
		'{8'h2C, 0, 0, 0}, '{8'hC4, 0, 0, 0}, '{8'h44, 1, 32'h1234_5678, 32'h1234_5678},
		'{8'h84, 1, 32'h0000_0505, 32'h0000_0505}, '{8'h5C, 1, 32'hABCD_1234, 32'h0000_1234},
		'{8'h54, 1, 32'h0000_1111, 0}, '{8'h48, 1, 32'hFFFF_FFFF, 0},
		'{8'hC4, 1, 32'h0000_00FF, 32'h0000_003F}, '{8'h64, 1, 32'h0000_0081, 0},
		'{8'h6C, 0, 0, 32'h0000_0081}, '{8'h68, 1, 32'h0000_0001, 0},
		'{8'h6C, 0, 0, 32'h0000_0080}};
	// trigger line and edge choices: mode word, line pulsed, flag expected
	tcc_trig_t trg [5] = '{'{32'h000, 1, 0}, '{32'h100, 1, 1}, '{32'h300, 1, 1},
		'{32'h500, 1, 0}, '{32'h600, 0, 1}};
	tcc_timer i_tcc_timer (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IO_A_IN(io_a_in), .IO_A_OUT(io_a_out),
		.IO_A_OE_N_OUT(io_a_oe_n), .IO_B_IN(io_b_in), .IO_B_OUT(io_b_out),
		.IO_B_OE_N_OUT(io_b_oe_n), .EXT_CLK_IN(ext_clk), .IRQ_OUT(irq));
	tcc_pins_model i_tcc_pins_model (.clk_in(clk), .dev_a_in(io_a_out),
		.dev_a_oe_n_in(io_a_oe_n), .dev_b_in(io_b_out), .dev_b_oe_n_in(io_b_oe_n),
		.pin_a_out(io_a_in), .pin_b_out(io_b_in), .ext_clk_out(ext_clk));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// data stand only in the cycle after the read edge
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// wait for line a to reach a level, bounded, and give the cycle
	task automatic wait_a(input logic v, output int t);
		int n;
		n = 0;
		// step off the edge so a level launched there is seen settled
		#1;
		while (io_a_out[0] !== v && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		t = cyc;
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// hang limit well above the roughly 420 cycles of the run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			end_sim();
		end
	end
	// ****
	// main sequence
	// ****
	initial begin
		logic [31:0] v, w;
		int t0, t1, t2;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		chk(32'({io_a_oe_n, io_b_oe_n, irq}), 32'h0000_01F8);
		foreach (rows[i]) begin
			if (rows[i].w)
				wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a, v);
			chk(v, rows[i].e);
		end
		// capture: a loads on rise, b on fall, second pulse before any read
		wr_reg(8'h04, 32'h0009_0000);
		wr_reg(8'h00, 32'h1);
		wr_reg(8'h00, 32'h4);
		i_tcc_pins_model.pulse(0, 20);
		repeat (5) @(posedge clk);
		i_tcc_pins_model.pulse(0, 7);
		repeat (5) @(posedge clk);
		// reading a clears its loaded flag only; b stays flagged
		rd_reg(8'h14, v);
		chk(32'(v[15:0] != 16'h0000), 32'h1);
		rd_reg(8'h20, w);
		chk(w & 32'h62, 32'h42);
		rd_reg(8'h18, w);
		chk(w - v, 32'h7);
		rd_reg(8'h20, v);
		chk(v & 32'h62, 32'h0);
		// external trigger line and edge choices
		foreach (trg[i]) begin
			wr_reg(8'h04, trg[i].m);
			rd_reg(8'h20, v);
			i_tcc_pins_model.pulse(trg[i].ln, 5);
			repeat (5) @(posedge clk);
			rd_reg(8'h20, v);
			chk(32'(v[7]), 32'(trg[i].e));
		end
		// pwm: set at a match 3, clear at period match 9, period reloads
		wr_reg(8'h04, 32'h0309_C400);
		wr_reg(8'h14, 32'h3);
		wr_reg(8'h18, 32'h5);
		wr_reg(8'h1C, 32'h9);
		wr_reg(8'h00, 32'h1);
		wr_reg(8'h00, 32'h4);
		wait_a(1'b0, t0);
		wait_a(1'b1, t0);
		wait_a(1'b0, t1);
		wait_a(1'b1, t2);
		chk(32'(t1 - t0), 32'h6);
		chk(32'(t2 - t0), 32'hA);
		// line b toggles once per period at its own match
		v = 32'(io_b_out[0]);
		repeat (10) @(posedge clk);
		#1 chk(32'(io_b_out[0]), ~v & 32'h1);
		chk(32'(io_b_oe_n[0]), 32'h0);
		rd_reg(8'h20, v);
		chk(v & 32'h1001C, 32'h1001C);
		wr_reg(8'h24, 32'h10);
		repeat (12) @(posedge clk);
		chk(32'(irq[0]), 32'h1);
		wr_reg(8'h28, 32'h10);
		repeat (3) @(posedge clk);
		chk(32'(irq[0]), 32'h0);
		// a match and period match together: period clear wins over set
		wr_reg(8'h14, 32'h9);
		repeat (25) @(posedge clk);
		chk(32'(io_a_out[0]), 32'h0);
		repeat (5) @(posedge clk);
		chk(32'(io_a_out[0]), 32'h0);
		// counter passing the top raises the wrap flag; line b is the event input
		wr_reg(8'h04, 32'h0010_9100);
		wr_reg(8'h10, 32'hFFF0);
		repeat (30) @(posedge clk);
		rd_reg(8'h20, v);
		chk(v & 32'h1, 32'h1);
		chk(32'(io_b_oe_n[0]), 32'h1);
		// rising event on line b sets line a and restarts the counter
		i_tcc_pins_model.pulse(1, 5);
		repeat (6) @(posedge clk);
		chk(32'(io_a_out[0]), 32'h1);
		rd_reg(8'h10, v);
		chk(32'(v < 16), 32'h1);
		rd_reg(8'h20, v);
		chk(v & 32'h80, 32'h80);
		// stop at period match, then disable at period match
		wr_reg(8'h04, 32'h0000_8040);
		wr_reg(8'h00, 32'h4);
		repeat (30) @(posedge clk);
		rd_reg(8'h10, v);
		rd_reg(8'h10, w);
		chk(w, v);
		chk(32'(v < 16), 32'h1);
		wr_reg(8'h04, 32'h0000_8080);
		wr_reg(8'h00, 32'h4);
		repeat (30) @(posedge clk);
		rd_reg(8'h20, v);
		chk(v & 32'h10000, 32'h0);
		// block command starts channels 1 and 2 together
		wr_reg(8'h40, 32'h1);
		wr_reg(8'h80, 32'h1);
		wr_reg(8'hC0, 32'h1);
		rd_reg(8'h50, v);
		rd_reg(8'h90, w);
		chk(w - v, 32'h2);
		// reset in mid-run brings back the idle state
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk(32'({io_a_oe_n, io_b_oe_n, irq}), 32'h0000_01F8);
		rd_reg(8'h04, v);
		chk(v, 32'h0);
		end_sim();
	end
endmodule
